// >>> hw/mevl_pkg.sv
package mevl_pkg;
	// ------------------------------------------------------------
	// register map (word index, byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [7:0] STATUS_SEL_IDX = 8'h0b;
	localparam logic [7:0] PROTECT_IDX = 8'h0c;
	localparam logic [7:0] INTERRUPT_OUTPUT_SEL_IDX = 8'h0d;
	localparam logic [7:0] EVENTS_IDX = 8'h0e;
	localparam logic [7:0] STOP_CTRL_IDX = 8'h20;
	localparam logic [7:0] VLEFT_POS_IDX = 8'h21;
	localparam logic [7:0] VRIGHT_POS_IDX = 8'h22;
	localparam logic [7:0] MOTION_STAT_IDX = 8'h23;
	localparam int unsigned ADDR_LSB = 2;
	localparam int unsigned ADDR_W = 10;
	localparam logic [31:0] STATUS_SEL_RST = 32'h8202_9805;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// ------------------------------------------------------------
	// event bit positions
	// ------------------------------------------------------------
	localparam int unsigned EV_LEFT_LIMIT_SWITCH = 11;
	localparam int unsigned EV_RIGHT_LIMIT_SWITCH = 12;
	localparam int unsigned EV_VLEFT = 13;
	localparam int unsigned EV_VRIGHT = 14;
	localparam int unsigned EV_HOME = 15;
	localparam int unsigned EV_XCAP = 16;
	localparam int unsigned EV_FS = 17;
	localparam int unsigned EV_ENCDEV = 18;
	localparam int unsigned EV_INDEX = 19;
	localparam int unsigned EV_ENCCAP = 20;
	localparam int unsigned EV_SERERR = 21;
	localparam int unsigned EV_RSVD = 22;
	localparam int unsigned EV_SERCFG = 23;
	localparam int unsigned EV_SERFLG = 24;
	localparam int unsigned EV_DGRAM = 25;
	localparam int unsigned EV_VEL0 = 26;
	localparam int unsigned EV_CLMAX = 27;
	localparam int unsigned EV_CLFIT = 28;
	localparam int unsigned EV_STALL = 29;
	localparam int unsigned EV_DRV = 30;
	localparam int unsigned EV_RST = 31;
	localparam int unsigned EV_LO = 11;
	localparam int unsigned STAT_BITS = 8;
	// stop control bits
	localparam int unsigned CTL_LEFT_LIMIT_SWITCH_EN = 0;
	localparam int unsigned CTL_RIGHT_LIMIT_SWITCH_EN = 1;
	localparam int unsigned CTL_VLEFT_EN = 2;
	localparam int unsigned CTL_VRIGHT_EN = 3;
	// ------------------------------------------------------------
	// event sources, one per event bit 15 to 30 except reserved bit 22
	// ------------------------------------------------------------
	typedef struct packed {
		logic driver_flag;
		logic stall;
		logic loop_fit;
		logic angle_max;
		logic enc_standstill;
		logic dgram_sent;
		logic ser_flags;
		logic ser_config;
		logic ser_error;
		logic enc_capture;
		logic enc_index;
		logic enc_deviation;
		logic fullstep;
		logic pos_capture;
		logic home_error;
	} mevl_src_s;
	// motion limit inputs
	typedef struct packed {
		logic left_switch;
		logic right_switch;
		logic vleft_hit;
		logic vright_hit;
	} mevl_lim_s;
endpackage : mevl_pkg

// >>> hw/mevl_top.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module mevl_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [mevl_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire mevl_pkg::mevl_src_s src_i,
	input wire mevl_pkg::mevl_lim_s lim_i,
	output logic neg_block_o,
	output logic pos_block_o,
	output logic ramp_stop_o,
	output logic interrupt_output_o,
	output logic [mevl_pkg::STAT_BITS-1:0] dgram_status_o
);
	// ------------------------------------------------------------
	// input synchronisers (pins from outside the clock domain)
	// ------------------------------------------------------------
	mevl_pkg::mevl_src_s src_m_q;
	mevl_pkg::mevl_src_s src_s_q;
	mevl_pkg::mevl_src_s src_p_q;
	mevl_pkg::mevl_lim_s lim_m_q;
	mevl_pkg::mevl_lim_s lim_s_q;
	mevl_pkg::mevl_lim_s lim_p_q;
	logic reset_seen_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_m_q <= '0;
			src_s_q <= '0;
			src_p_q <= '0;
			lim_m_q <= '0;
			lim_s_q <= '0;
			lim_p_q <= '0;
		end else begin
			src_m_q <= src_i;
			src_s_q <= src_m_q;
			src_p_q <= src_s_q;
			lim_m_q <= lim_i;
			lim_s_q <= lim_m_q;
			lim_p_q <= lim_s_q;
		end
	end

	// ------------------------------------------------------------
	// wishbone decode
	// ------------------------------------------------------------
	logic [31:0] status_sel_q;
	logic [31:0] protect_q;
	logic [31:0] interrupt_output_sel_q;
	logic [31:0] stop_ctrl_q;
	logic [31:0] vleft_pos_q;
	logic [31:0] vright_pos_q;
	logic [31:0] events_q;
	logic [31:0] events_d;
	logic ack_q;
	logic [31:0] dat_q;
	logic neg_q;
	logic pos_q;
	logic stall_q;
	logic interrupt_output_q;
	logic [mevl_pkg::STAT_BITS-1:0] stat_q;

	wire [7:0] idx = wb_adr_i[mevl_pkg::ADDR_W-1:mevl_pkg::ADDR_LSB];
	wire req = wb_cyc_i && wb_stb_i && !ack_q;
	wire wr = req && wb_we_i;
	wire rd = req && !wb_we_i;
	wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire wr_ssel = wr && (idx == mevl_pkg::STATUS_SEL_IDX);
	wire wr_prot = wr && (idx == mevl_pkg::PROTECT_IDX);
	wire wr_isel = wr && (idx == mevl_pkg::INTERRUPT_OUTPUT_SEL_IDX);
	wire wr_ctl = wr && (idx == mevl_pkg::STOP_CTRL_IDX);
	wire wr_vl = wr && (idx == mevl_pkg::VLEFT_POS_IDX);
	wire wr_vr = wr && (idx == mevl_pkg::VRIGHT_POS_IDX);
	wire rd_ev = rd && (idx == mevl_pkg::EVENTS_IDX);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	function automatic logic [31:0] at_bit(input logic b, input int unsigned pos);
		at_bit = {31'h0000_0000, b} << pos;
	endfunction : at_bit

	// the interrupt follows the select value being written, so it never lags the register by a cycle
	wire [31:0] interrupt_output_sel_d = wr_isel ? merge(interrupt_output_sel_q, wb_dat_i, bmask) : interrupt_output_sel_q;

	// ------------------------------------------------------------
	// event set terms
	// ------------------------------------------------------------
	wire [31:0] rise_src;
	wire [31:0] set_v;
	wire left_limit_switch_en = stop_ctrl_q[mevl_pkg::CTL_LEFT_LIMIT_SWITCH_EN];
	wire right_limit_switch_en = stop_ctrl_q[mevl_pkg::CTL_RIGHT_LIMIT_SWITCH_EN];
	wire vl_en = stop_ctrl_q[mevl_pkg::CTL_VLEFT_EN];
	wire vr_en = stop_ctrl_q[mevl_pkg::CTL_VRIGHT_EN];
	wire left_limit_switch_trig = left_limit_switch_en && lim_s_q.left_switch && !lim_p_q.left_switch;
	wire right_limit_switch_trig = right_limit_switch_en && lim_s_q.right_switch && !lim_p_q.right_switch;
	wire vl_trig = vl_en && lim_s_q.vleft_hit && !lim_p_q.vleft_hit;
	wire vr_trig = vr_en && lim_s_q.vright_hit && !lim_p_q.vright_hit;
	// sources are rising-edge detected so a held condition fires once
	wire mevl_pkg::mevl_src_s src_rise = src_s_q & ~src_p_q;

	// each source is placed by name: bit 22 has no source, so a plain shift would put the upper eight one bit low
	assign rise_src = at_bit(src_rise.home_error, mevl_pkg::EV_HOME)
		| at_bit(src_rise.pos_capture, mevl_pkg::EV_XCAP)
		| at_bit(src_rise.fullstep, mevl_pkg::EV_FS)
		| at_bit(src_rise.enc_deviation, mevl_pkg::EV_ENCDEV)
		| at_bit(src_rise.enc_index, mevl_pkg::EV_INDEX)
		| at_bit(src_rise.enc_capture, mevl_pkg::EV_ENCCAP)
		| at_bit(src_rise.ser_error, mevl_pkg::EV_SERERR)
		| at_bit(src_rise.ser_config, mevl_pkg::EV_SERCFG)
		| at_bit(src_rise.ser_flags, mevl_pkg::EV_SERFLG)
		| at_bit(src_rise.dgram_sent, mevl_pkg::EV_DGRAM)
		| at_bit(src_rise.enc_standstill, mevl_pkg::EV_VEL0)
		| at_bit(src_rise.angle_max, mevl_pkg::EV_CLMAX)
		| at_bit(src_rise.loop_fit, mevl_pkg::EV_CLFIT)
		| at_bit(src_rise.stall, mevl_pkg::EV_STALL)
		| at_bit(src_rise.driver_flag, mevl_pkg::EV_DRV);
	assign set_v = rise_src
		| at_bit(left_limit_switch_trig, mevl_pkg::EV_LEFT_LIMIT_SWITCH)
		| at_bit(right_limit_switch_trig, mevl_pkg::EV_RIGHT_LIMIT_SWITCH)
		| at_bit(vl_trig, mevl_pkg::EV_VLEFT)
		| at_bit(vr_trig, mevl_pkg::EV_VRIGHT)
		| at_bit(reset_seen_q, mevl_pkg::EV_RST);

	// bit 22 has no source and the lower bits belong to the other half; both are masked
	wire [31:0] upper_mask = ~((32'h0000_0001 << mevl_pkg::EV_LO) - 32'h0000_0001);
	wire [31:0] rsvd_mask = ~(32'h0000_0001 << mevl_pkg::EV_RSVD);
	wire [31:0] clr_v = rd_ev ? ~protect_q : mevl_pkg::ZERO32;

	// set wins over a clear in the same cycle
	assign events_d = ((events_q & ~clr_v) | set_v) & upper_mask & rsvd_mask;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_seen_q <= 1'b1;
			events_q <= mevl_pkg::ZERO32;
			status_sel_q <= mevl_pkg::STATUS_SEL_RST;
			protect_q <= mevl_pkg::ZERO32;
			interrupt_output_sel_q <= mevl_pkg::ZERO32;
			stop_ctrl_q <= mevl_pkg::ZERO32;
			vleft_pos_q <= mevl_pkg::ZERO32;
			vright_pos_q <= mevl_pkg::ZERO32;
		end else begin
			reset_seen_q <= 1'b0;
			events_q <= events_d;
			if (wr_ssel) status_sel_q <= merge(status_sel_q, wb_dat_i, bmask);
			if (wr_prot) protect_q <= merge(protect_q, wb_dat_i, bmask);
			interrupt_output_sel_q <= interrupt_output_sel_d;
			if (wr_ctl) stop_ctrl_q <= merge(stop_ctrl_q, wb_dat_i, bmask);
			if (wr_vl) vleft_pos_q <= merge(vleft_pos_q, wb_dat_i, bmask);
			if (wr_vr) vright_pos_q <= merge(vright_pos_q, wb_dat_i, bmask);
		end
	end

	// ------------------------------------------------------------
	// motion inhibit
	// ------------------------------------------------------------
	// a block releases only after its event is cleared and either the cause is gone (switch released, new virtual position written) or its stop is disabled
	wire neg_rel_sw = !events_q[mevl_pkg::EV_LEFT_LIMIT_SWITCH] && (!lim_s_q.left_switch || !left_limit_switch_en);
	wire pos_rel_sw = !events_q[mevl_pkg::EV_RIGHT_LIMIT_SWITCH] && (!lim_s_q.right_switch || !right_limit_switch_en);
	logic vl_blk_q;
	logic vr_blk_q;
	logic sl_blk_q;
	logic sr_blk_q;
	wire vl_blk_d = vl_trig || (vl_blk_q && !(!events_q[mevl_pkg::EV_VLEFT] && (wr_vl || !vl_en)));
	wire vr_blk_d = vr_trig || (vr_blk_q && !(!events_q[mevl_pkg::EV_VRIGHT] && (wr_vr || !vr_en)));
	wire sl_blk_d = left_limit_switch_trig || (sl_blk_q && !neg_rel_sw);
	wire sr_blk_d = right_limit_switch_trig || (sr_blk_q && !pos_rel_sw);
	wire [31:0] rd_mux =
		(idx == mevl_pkg::STATUS_SEL_IDX) ? status_sel_q :
		(idx == mevl_pkg::PROTECT_IDX) ? protect_q :
		(idx == mevl_pkg::INTERRUPT_OUTPUT_SEL_IDX) ? interrupt_output_sel_q :
		(idx == mevl_pkg::EVENTS_IDX) ? events_q :
		(idx == mevl_pkg::STOP_CTRL_IDX) ? stop_ctrl_q :
		(idx == mevl_pkg::VLEFT_POS_IDX) ? vleft_pos_q :
		(idx == mevl_pkg::VRIGHT_POS_IDX) ? vright_pos_q :
		(idx == mevl_pkg::MOTION_STAT_IDX) ? {28'h000_0000, sr_blk_q, sl_blk_q, pos_q, neg_q} :
		mevl_pkg::ZERO32;
	// limitation: the status byte carries the low eight event bits, which this half never sets
	wire [31:0] ssel_ev = events_q & status_sel_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vl_blk_q <= 1'b0;
			vr_blk_q <= 1'b0;
			sl_blk_q <= 1'b0;
			sr_blk_q <= 1'b0;
			neg_q <= 1'b0;
			pos_q <= 1'b0;
			stall_q <= 1'b0;
			interrupt_output_q <= 1'b0;
			stat_q <= '0;
			ack_q <= 1'b0;
			dat_q <= mevl_pkg::ZERO32;
		end else begin
			vl_blk_q <= vl_blk_d;
			vr_blk_q <= vr_blk_d;
			sl_blk_q <= sl_blk_d;
			sr_blk_q <= sr_blk_d;
			neg_q <= sl_blk_d || vl_blk_d;
			pos_q <= sr_blk_d || vr_blk_d;
			stall_q <= events_d[mevl_pkg::EV_STALL];
			interrupt_output_q <= |(events_d & interrupt_output_sel_d);
			stat_q <= ssel_ev[mevl_pkg::STAT_BITS-1:0];
			ack_q <= req;
			dat_q <= rd ? rd_mux : mevl_pkg::ZERO32;
		end
	end

	assign neg_block_o = neg_q;
	assign pos_block_o = pos_q;
	assign ramp_stop_o = stall_q;
	assign interrupt_output_o = interrupt_output_q;
	assign dgram_status_o = stat_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ------------------------------------------------------------
	// event latch checks
	// ------------------------------------------------------------
	a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		!events_q[mevl_pkg::EV_RSVD])
		else $error("reserved event bit set");
	a_lower_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		events_q[mevl_pkg::EV_LO-1:0] == '0)
		else $error("lower event bits set in upper half");
	a_reset_event: assert property (@(posedge clk_i) disable iff (rst_i)
		reset_seen_q |=> events_q[mevl_pkg::EV_RST])
		else $error("reset event not latched");
	a_event_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		events_q[mevl_pkg::EV_DGRAM] && !rd_ev |=> events_q[mevl_pkg::EV_DGRAM])
		else $error("event dropped without a read");
	a_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_ev && (set_v == mevl_pkg::ZERO32) |=> ((events_q & ~protect_q) == mevl_pkg::ZERO32))
		else $error("read did not clear unprotected events");
	a_protect_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_ev |=> ((~events_q & $past(events_q) & protect_q) == mevl_pkg::ZERO32))
		else $error("protected event cleared by a read");
	a_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_ev |=> (wb_dat_o == $past(events_q)))
		else $error("event read returned wrong data");
	a_home_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.home_error |=> events_q[mevl_pkg::EV_HOME])
		else $error("home error event not latched");
	a_poscap_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.pos_capture |=> events_q[mevl_pkg::EV_XCAP])
		else $error("position capture event not latched");
	a_fullstep_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.fullstep |=> events_q[mevl_pkg::EV_FS])
		else $error("fullstep event not latched");
	a_encdev_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.enc_deviation |=> events_q[mevl_pkg::EV_ENCDEV])
		else $error("encoder deviation event not latched");
	a_index_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.enc_index |=> events_q[mevl_pkg::EV_INDEX])
		else $error("encoder index event not latched");
	a_enccap_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.enc_capture |=> events_q[mevl_pkg::EV_ENCCAP])
		else $error("encoder capture event not latched");
	a_sererr_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.ser_error |=> events_q[mevl_pkg::EV_SERERR])
		else $error("serial encoder error event not latched");
	a_sercfg_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.ser_config |=> events_q[mevl_pkg::EV_SERCFG])
		else $error("serial encoder config event not latched");
	a_serflag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.ser_flags |=> events_q[mevl_pkg::EV_SERFLG])
		else $error("serial encoder flag event not latched");
	a_dgram_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.dgram_sent |=> events_q[mevl_pkg::EV_DGRAM])
		else $error("datagram event not latched");
	a_vel_zero_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.enc_standstill |=> events_q[mevl_pkg::EV_VEL0])
		else $error("encoder standstill event not latched");
	a_angle_max_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.angle_max |=> events_q[mevl_pkg::EV_CLMAX])
		else $error("commutation angle event not latched");
	a_loop_fit_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.loop_fit |=> events_q[mevl_pkg::EV_CLFIT])
		else $error("loop fit event not latched");
	a_stall_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.stall |=> events_q[mevl_pkg::EV_STALL])
		else $error("stall event not latched");
	a_driver_set: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.driver_flag |=> events_q[mevl_pkg::EV_DRV])
		else $error("driver flag event not latched");

	// ------------------------------------------------------------
	// inhibit, interrupt and bus checks
	// ------------------------------------------------------------
	a_left_limit_switch_event: assert property (@(posedge clk_i) disable iff (rst_i)
		left_limit_switch_trig |=> events_q[mevl_pkg::EV_LEFT_LIMIT_SWITCH])
		else $error("left switch event not latched");
	a_left_limit_switch_block: assert property (@(posedge clk_i) disable iff (rst_i)
		left_limit_switch_trig |=> ##1 neg_block_o)
		else $error("left switch did not block negative motion");
	a_left_limit_switch_release: assert property (@(posedge clk_i) disable iff (rst_i)
		sl_blk_q && !events_q[mevl_pkg::EV_LEFT_LIMIT_SWITCH] && (!lim_s_q.left_switch || !left_limit_switch_en) |=> !sl_blk_q)
		else $error("left switch block not released");
	a_right_limit_switch_event: assert property (@(posedge clk_i) disable iff (rst_i)
		right_limit_switch_trig |=> events_q[mevl_pkg::EV_RIGHT_LIMIT_SWITCH])
		else $error("right switch event not latched");
	a_right_limit_switch_block: assert property (@(posedge clk_i) disable iff (rst_i)
		right_limit_switch_trig |=> ##1 pos_block_o)
		else $error("right switch did not block positive motion");
	a_right_limit_switch_release: assert property (@(posedge clk_i) disable iff (rst_i)
		sr_blk_q && !events_q[mevl_pkg::EV_RIGHT_LIMIT_SWITCH] && (!lim_s_q.right_switch || !right_limit_switch_en) |=> !sr_blk_q)
		else $error("right switch block not released");
	a_vleft_event: assert property (@(posedge clk_i) disable iff (rst_i)
		vl_trig |=> events_q[mevl_pkg::EV_VLEFT])
		else $error("virtual left event not latched");
	a_vleft_block: assert property (@(posedge clk_i) disable iff (rst_i)
		vl_trig |=> neg_block_o)
		else $error("virtual left did not block negative motion");
	a_vleft_release: assert property (@(posedge clk_i) disable iff (rst_i)
		vl_blk_q && !events_q[mevl_pkg::EV_VLEFT] && wr_vl && !vl_trig |=> !vl_blk_q)
		else $error("virtual left block not released by new position");
	a_vright_event: assert property (@(posedge clk_i) disable iff (rst_i)
		vr_trig |=> events_q[mevl_pkg::EV_VRIGHT])
		else $error("virtual right event not latched");
	a_vright_block: assert property (@(posedge clk_i) disable iff (rst_i)
		vr_trig |=> pos_block_o)
		else $error("virtual right did not block positive motion");
	a_vright_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		vr_blk_q && events_q[mevl_pkg::EV_VRIGHT] |=> vr_blk_q)
		else $error("virtual right block released early");
	a_vright_release: assert property (@(posedge clk_i) disable iff (rst_i)
		vr_blk_q && !events_q[mevl_pkg::EV_VRIGHT] && !vr_en |=> !vr_blk_q)
		else $error("virtual right block not released when disabled");
	a_stall_stop: assert property (@(posedge clk_i) disable iff (rst_i)
		src_rise.stall |=> ##1 ramp_stop_o)
		else $error("stall did not stop ramp");
	a_stall_level: assert property (@(posedge clk_i) disable iff (rst_i)
		ramp_stop_o == events_q[mevl_pkg::EV_STALL])
		else $error("ramp stop differs from stall event");
	a_interrupt_output_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		|(events_q & interrupt_output_sel_q) |-> interrupt_output_o)
		else $error("interrupt missing");
	a_irq_low: assert property (@(posedge clk_i) disable iff (rst_i)
		((events_q & interrupt_output_sel_q) == mevl_pkg::ZERO32) |-> !interrupt_output_o)
		else $error("interrupt without a selected event");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	a_idle_data: assert property (@(posedge clk_i) disable iff (rst_i)
		!wb_ack_o |-> (wb_dat_o == mevl_pkg::ZERO32))
		else $error("read data not zero outside acknowledge");
endmodule : mevl_top

// >>> verification/mevl_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side: classic wishbone master, one transfer at a time
// ------------------------------------------------------------
module mevl_host (
	input wire logic clk_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [mevl_pkg::ADDR_W-1:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic [31:0] dat_i,
	input wire logic ack_i
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = '0;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
	end
	// request held until ack is seen; the entry edge keeps stb low for a cycle between transfers
	task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= we;
		adr_o <= {idx, 2'b00};
		sel_o <= 4'hf;
		dat_o <= wd;
		do @(posedge clk_i); while (ack_i !== 1'b1);
		rd = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
	endtask : xfer
endmodule : mevl_host

// >>> verification/mevl_top_tb.sv
`timescale 1ns/1ps
module mevl_top_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack, neg_blk, pos_blk, ramp_stop, irq;
	logic [mevl_pkg::ADDR_W-1:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [7:0] dstat;
	mevl_pkg::mevl_src_s src = '0;
	mevl_pkg::mevl_lim_s lim = '0;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc_cnt = 0;
	initial forever #5 clk_i = ~clk_i;
	mevl_host host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
		.dat_o(wdat), .dat_i(rdat), .ack_i(ack));
	mevl_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .src_i(src), .lim_i(lim),
		.neg_block_o(neg_blk), .pos_block_o(pos_blk), .ramp_stop_o(ramp_stop),
		.interrupt_output_o(irq), .dgram_status_o(dstat));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] r;
		host.xfer(1'b1, idx, d, r);
	endtask : wr
	task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] r;
		host.xfer(1'b0, idx, 32'h0000_0000, r);
		chk(what, exp, r);
	endtask : rd_chk
	// source pulse is dropped before the read so latching is what gets seen
	task automatic pulse(input int k);
		@(posedge clk_i);
		src <= mevl_pkg::mevl_src_s'(15'h0001 << k);
		tick(2);
		src <= '0;
		tick(4);
	endtask : pulse
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		tick(2);
		rd_chk("status_sel", mevl_pkg::STATUS_SEL_IDX, mevl_pkg::STATUS_SEL_RST);
		rd_chk("protect", mevl_pkg::PROTECT_IDX, 32'h0000_0000);
		rd_chk("interrupt_output_sel", mevl_pkg::INTERRUPT_OUTPUT_SEL_IDX, 32'h0000_0000);
		rd_chk("unmapped", 8'h3f, 32'h0000_0000);
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h8000_0000);
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h0000_0000);
	endtask : t_reset
	task automatic t_sources();
		int pos;
		for (int k = 0; k < 15; k++) begin
			pos = (k < 7) ? 15 + k : 16 + k;
			pulse(k);
			if (k == 13) chk("ramp_stop", 32'h1, {31'h0, ramp_stop});
			rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h1 << pos);
		end
	endtask : t_sources
	task automatic t_protect();
		wr(mevl_pkg::PROTECT_IDX, 32'h0200_0000);
		pulse(9);
		pulse(10);
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h0600_0000);
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h0200_0000);
		wr(mevl_pkg::PROTECT_IDX, 32'h0000_0000);
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h0200_0000);
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h0000_0000);
	endtask : t_protect
	task automatic t_irq_status();
		wr(mevl_pkg::INTERRUPT_OUTPUT_SEL_IDX, 32'h0400_0000);
		wr(mevl_pkg::STATUS_SEL_IDX, 32'hffff_ffff);
		pulse(9);
		chk("irq", 32'h0, {31'h0, irq});
		chk("dgram_status", 32'h0, {24'h0, dstat});
		pulse(10);
		chk("irq", 32'h1, {31'h0, irq});
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h0600_0000);
		tick(2);
		chk("irq", 32'h0, {31'h0, irq});
		wr(mevl_pkg::INTERRUPT_OUTPUT_SEL_IDX, 32'h0000_0000);
		wr(mevl_pkg::STATUS_SEL_IDX, mevl_pkg::STATUS_SEL_RST);
	endtask : t_irq_status
	task automatic t_limits();
		wr(mevl_pkg::STOP_CTRL_IDX, 32'h0000_000f);
		lim.left_switch <= 1'b1;
		tick(5);
		lim.left_switch <= 1'b0;
		tick(5);
		chk("neg_block", 32'h1, {31'h0, neg_blk});
		chk("pos_block", 32'h0, {31'h0, pos_blk});
		rd_chk("motion_stat", mevl_pkg::MOTION_STAT_IDX, 32'h0000_0005);
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h0000_0800);
		tick(3);
		chk("neg_block", 32'h0, {31'h0, neg_blk});
		lim.right_switch <= 1'b1;
		tick(5);
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h0000_1000);
		tick(3);
		chk("pos_block", 32'h1, {31'h0, pos_blk});
		wr(mevl_pkg::STOP_CTRL_IDX, 32'h0000_000d);
		tick(3);
		chk("pos_block", 32'h0, {31'h0, pos_blk});
		lim.right_switch <= 1'b0;
		lim.vleft_hit <= 1'b1;
		lim.vright_hit <= 1'b1;
		tick(5);
		lim.vleft_hit <= 1'b0;
		lim.vright_hit <= 1'b0;
		rd_chk("events", mevl_pkg::EVENTS_IDX, 32'h0000_6000);
		tick(3);
		chk("blocks", 32'h3, {30'h0, pos_blk, neg_blk});
		rd_chk("motion_stat", mevl_pkg::MOTION_STAT_IDX, 32'h0000_0003);
		wr(mevl_pkg::VLEFT_POS_IDX, 32'h0000_1234);
		wr(mevl_pkg::STOP_CTRL_IDX, 32'h0000_0005);
		tick(3);
		chk("blocks", 32'h0, {30'h0, pos_blk, neg_blk});
	endtask : t_limits
	initial begin
		tick(16);
		rst_i <= 1'b0;
		t_reset();
		t_sources();
		t_protect();
		t_irq_status();
		t_limits();
		complete_run();
	end
endmodule : mevl_top_tb
